//--- gss_core.sv
`timescale 1ns/1ns
`default_nettype none
// What this block does
// - sync trigger on scaled clock, then raise gate
// - gate (GATE_O) stays high at least 200 ns
// - three-stage delay of trigger after counting starts
// - delayed trigger strobes output translator within 800 ns at divide ratio 1
// - first gate pulse injected from delayed trigger
// - terminal flag low only at terminal count
// - gate pulses pass when enabled, flag low, trigger high
// - block completion raises active-low interrupt
// - status read low drives status onto data bus
// - idle: latch select follows cpu address bits
// - measuring: upper select high, low bit xor
// - single flag high single, toggle input toggles dual
// - select 111 single with toggle low, alternates 110/111 dual
// - sample word: four interp bits, two totalize bits
// - buffer enable, ram select and write strobe
// - sample reads disable inputs, enable bidirectional buffers
// - totalize latch captures carry flags each write
// - totalize latch clocked by strobe delayed 50 ns
// - high carry flag means count correct
// - overflow latches capture counter msb carries while toggle input high
// - overflow flags feed interrupt and status read
// - scaled clock from programmable 1..16 divider
module gss_core
  import gss_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int INTERP_W = 4
) (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic SRST_I,
  // divider control
  input wire logic [3:0] DIV_RATIO_I,
  // sequencer side
  input wire logic TIMING_TRIGGER_I,
  input wire logic [1:0] TERMINAL_COUNT_I,
  input wire logic [15:0] TERMINAL_RELOAD_I,
  input wire logic BLOCK_DONE_I,
  input wire logic EXT_ARM_STATE_I,
  input wire logic RAM_TC_I,
  // channel select
  input wire logic ACQUISITION_IDLE_I,
  input wire logic [2:0] CPU_ADDR_LOW_BITS_I,
  input wire logic CHANNEL_TOGGLE_TTL_I,
  input wire logic SINGLE_CHANNEL_FLAG_I,
  input wire logic CHANNEL_TOGGLE_IN_I,
  // sample ram path
  input wire logic INTERP_VALID_I,
  input wire logic [INTERP_W-1:0] INTERP_DATA_I,
  input wire logic [1:0] LATCH_CARRY_FLAGS_I,
  input wire logic SAMPLE_WRITE_STROBE_I,
  input wire logic INTERP_RAM_SELECT_I,
  input wire logic SAMPLE_READ_I,
  input wire logic COUNT_BUS_DIRECTION_I,
  input wire logic [1:0] COUNTER_MSB_CARRY_I,
  // processor bus
  input wire logic STATUS_READ_N_I,
  input wire logic [DATA_W-1:0] LOCAL_DATA_BUS_I,
  // outputs
  output logic SCALED_COUNT_CLOCK_O,
  output logic [1:0] GATE_O,
  output logic [1:0] TIMER_TERMINAL_FLAG_O,
  output logic STROBE_ENABLE_O,
  output logic GATE_PULSE_ONE_O,
  output logic GATE_PULSE_TWO_O,
  output logic BLOCK_DONE_IRQ_N_O,
  output logic [2:0] COUNTER_LATCH_SELECT_O,
  output logic INTERP_INPUT_BUF_EN_O,
  output logic [SW_WIDTH-1:0] SAMPLE_WORD_O,
  output logic START_RAM_WE_O,
  output logic STOP_RAM_WE_O,
  output logic BIDIR_BUF_EN_O,
  output logic [DATA_W-1:0] LOCAL_DATA_BUS_O,
  output logic LOCAL_DATA_BUS_OE_O,
  output logic [1:0] OVERFLOW_FLAGS_O
);

  // pin synchronisers
  logic [1:0] trig_s;
  logic [1:0] idle_s;
  logic [1:0] tog_s;
  logic [1:0] single_s;
  logic [1:0] wstb_s;
  logic [1:0] tin_s;
  logic [1:0] stat_s;
  logic [1:0] xarm_s;
  logic [1:0] rtc_s;
  logic [1:0] done_s;
  logic [1:0] carry0_s;
  logic [1:0] carry1_s;
  logic [1:0] msb0_s;
  logic [1:0] msb1_s;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      trig_s <= 2'h0;
      idle_s <= 2'h3;
      tog_s <= 2'h0;
      single_s <= 2'h0;
      wstb_s <= 2'h0;
      tin_s <= 2'h0;
    end else begin
      trig_s <= {trig_s[0], TIMING_TRIGGER_I};
      idle_s <= {idle_s[0], ACQUISITION_IDLE_I};
      tog_s <= {tog_s[0], CHANNEL_TOGGLE_TTL_I};
      single_s <= {single_s[0], SINGLE_CHANNEL_FLAG_I};
      wstb_s <= {wstb_s[0], SAMPLE_WRITE_STROBE_I};
      tin_s <= {tin_s[0], CHANNEL_TOGGLE_IN_I};
    end
  end

  // status pin synchronisers
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      stat_s <= 2'h3;
      xarm_s <= 2'h0;
      rtc_s <= 2'h0;
      done_s <= 2'h0;
    end else begin
      stat_s <= {stat_s[0], STATUS_READ_N_I};
      xarm_s <= {xarm_s[0], EXT_ARM_STATE_I};
      rtc_s <= {rtc_s[0], RAM_TC_I};
      done_s <= {done_s[0], BLOCK_DONE_I};
    end
  end

  // carry pin synchronisers
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      carry0_s <= 2'h0;
      carry1_s <= 2'h0;
      msb0_s <= 2'h0;
      msb1_s <= 2'h0;
    end else begin
      carry0_s <= {carry0_s[0], LATCH_CARRY_FLAGS_I[0]};
      carry1_s <= {carry1_s[0], LATCH_CARRY_FLAGS_I[1]};
      msb0_s <= {msb0_s[0], COUNTER_MSB_CARRY_I[0]};
      msb1_s <= {msb1_s[0], COUNTER_MSB_CARRY_I[1]};
    end
  end

  // scaled clock divider, ratio field 0 means 16
  logic [3:0] div_cnt;
  logic sc_tick;
  assign sc_tick = (div_cnt == DIV_RATIO_I - 4'h1);
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      div_cnt <= DIV_RESET;
    end else if (SRST_I || sc_tick) begin
      div_cnt <= DIV_RESET;
    end else begin
      div_cnt <= div_cnt + 4'h1;
    end
  end
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SCALED_COUNT_CLOCK_O <= 1'b0;
    end else begin
      SCALED_COUNT_CLOCK_O <= sc_tick;
    end
  end

  // trigger synchroniser and gate
  gss_gate_t gate_st;
  logic [3:0] gate_cnt;
  logic [TRIG_DELAY_STAGES-1:0] trig_dly;
  logic trig_prev;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      gate_st <= GS_IDLE;
      gate_cnt <= 4'h0;
    end else if (SRST_I) begin
      gate_st <= GS_IDLE;
      gate_cnt <= 4'h0;
    end else begin
      unique case (gate_st)
        GS_IDLE: begin
          if (trig_s[1]) begin
            gate_st <= GS_SYNC;
          end
        end
        GS_SYNC: begin
          if (sc_tick) begin
            gate_st <= GS_PULSE;
            gate_cnt <= 4'h0;
          end
        end
        GS_PULSE: begin
          if (gate_cnt < 4'(GATE_MIN_CYC)) begin
            gate_cnt <= gate_cnt + 4'h1;
          end else if (!trig_s[1]) begin
            gate_st <= GS_IDLE;
          end
        end
        default: begin
          gate_st <= GS_IDLE;
        end
      endcase
    end
  end
  assign GATE_O = {2{gate_st == GS_PULSE}};

  // three-stage delay on scaled clock ticks
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      trig_dly <= '0;
    end else if (SRST_I || gate_st == GS_IDLE) begin
      trig_dly <= '0;
    end else if (sc_tick) begin
      trig_dly <= {trig_dly[TRIG_DELAY_STAGES-2:0], trig_s[1]};
    end
  end
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      STROBE_ENABLE_O <= 1'b0;
    end else begin
      STROBE_ENABLE_O <= trig_dly[TRIG_DELAY_STAGES-1];
    end
  end

  // delayed trigger edge memory
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      trig_prev <= 1'b0;
    end else begin
      trig_prev <= trig_dly[TRIG_DELAY_STAGES-1];
    end
  end

  // terminal count timers
  logic [15:0] tc_cnt [2];
  logic [1:0] tflag;
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
        tc_cnt[g] <= 16'h0;
        tflag[g] <= 1'b1;
      end else if (SRST_I || gate_st != GS_PULSE && !STROBE_ENABLE_O) begin
        tc_cnt[g] <= 16'h0;
        tflag[g] <= 1'b1;
      end else if (sc_tick) begin
        if (TERMINAL_COUNT_I[g] || tc_cnt[g] == TERMINAL_RELOAD_I) begin
          tc_cnt[g] <= 16'h0;
          tflag[g] <= 1'b0;
        end else begin
          tc_cnt[g] <= tc_cnt[g] + 16'h1;
          tflag[g] <= 1'b1;
        end
      end
    end
  end
  assign TIMER_TERMINAL_FLAG_O = tflag;

  // gate pulse outputs
  logic [1:0] tflag_prev;
  logic inject;
  logic [1:0] tflag_fall;
  logic pulse_ok;
  assign inject = trig_dly[TRIG_DELAY_STAGES-1] && !trig_prev;
  assign tflag_fall = tflag_prev & ~tflag;
  assign pulse_ok = STROBE_ENABLE_O && trig_s[1];
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tflag_prev <= 2'h3;
      GATE_PULSE_ONE_O <= 1'b0;
      GATE_PULSE_TWO_O <= 1'b0;
    end else begin
      tflag_prev <= tflag;
      GATE_PULSE_ONE_O <= inject || pulse_ok && tflag_fall[0];
      GATE_PULSE_TWO_O <= inject || pulse_ok && tflag_fall[1];
    end
  end

  // latch select multiplexer
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      COUNTER_LATCH_SELECT_O <= 3'h0;
    end else if (idle_s[1]) begin
      COUNTER_LATCH_SELECT_O <= CPU_ADDR_LOW_BITS_I;
    end else begin
      COUNTER_LATCH_SELECT_O <= {SEL_UPPER_MEAS, tog_s[1] ^ single_s[1]};
    end
  end

  // sample ram write path
  logic [CARRY_DLY_CYC:0] wstb_dly;
  logic [1:0] tot_latch;
  logic wstb_fall;
  logic ram_wr;
  assign wstb_fall = wstb_dly[CARRY_DLY_CYC] && !wstb_dly[0];
  assign ram_wr = wstb_s[1] && !SAMPLE_READ_I;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wstb_dly <= '0;
    end else begin
      wstb_dly <= {wstb_dly[CARRY_DLY_CYC-1:0], wstb_s[1]};
    end
  end
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      tot_latch <= 2'h0;
    end else if (SRST_I) begin
      tot_latch <= 2'h0;
    end else if (wstb_fall) begin
      tot_latch <= {carry1_s[1], carry0_s[1]};
    end
  end
  assign INTERP_INPUT_BUF_EN_O = INTERP_VALID_I && !SAMPLE_READ_I;
  assign BIDIR_BUF_EN_O = SAMPLE_READ_I;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      SAMPLE_WORD_O <= '0;
      START_RAM_WE_O <= 1'b0;
      STOP_RAM_WE_O <= 1'b0;
    end else begin
      SAMPLE_WORD_O[SW_INTERP_LSB +: INTERP_W] <= INTERP_DATA_I;
      SAMPLE_WORD_O[SW_TOT_LSB +: 2] <= tot_latch;
      START_RAM_WE_O <= ram_wr && !INTERP_RAM_SELECT_I;
      STOP_RAM_WE_O <= ram_wr && INTERP_RAM_SELECT_I;
    end
  end

  // overflow latches
  logic [1:0] msb_prev;
  logic [1:0] msb_now;
  logic [1:0] msb_rise;
  assign msb_now = {msb1_s[1], msb0_s[1]};
  assign msb_rise = msb_now & ~msb_prev;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      msb_prev <= 2'h0;
      OVERFLOW_FLAGS_O <= 2'h0;
    end else begin
      msb_prev <= msb_now;
      if (SRST_I) begin
        OVERFLOW_FLAGS_O <= 2'h0;
      end else if (tin_s[1]) begin
        OVERFLOW_FLAGS_O <= OVERFLOW_FLAGS_O | msb_rise;
      end
    end
  end

  // interrupt
  logic irq_cause;
  assign irq_cause = done_s[1] || |OVERFLOW_FLAGS_O;
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      BLOCK_DONE_IRQ_N_O <= 1'b1;
    end else if (SRST_I) begin
      BLOCK_DONE_IRQ_N_O <= 1'b1;
    end else begin
      BLOCK_DONE_IRQ_N_O <= !irq_cause;
    end
  end

  // status and sample read bus
  always_ff @(posedge MCLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      LOCAL_DATA_BUS_O <= '0;
      LOCAL_DATA_BUS_OE_O <= 1'b0;
    end else if (!stat_s[1]) begin
      LOCAL_DATA_BUS_O <= '0;
      LOCAL_DATA_BUS_O[ST_EXT_ARM] <= xarm_s[1];
      LOCAL_DATA_BUS_O[ST_RAM_TC] <= rtc_s[1];
      LOCAL_DATA_BUS_O[ST_OVF_A] <= OVERFLOW_FLAGS_O[0];
      LOCAL_DATA_BUS_O[ST_OVF_B] <= OVERFLOW_FLAGS_O[1];
      LOCAL_DATA_BUS_OE_O <= 1'b1;
    end else begin
      LOCAL_DATA_BUS_O <= LOCAL_DATA_BUS_I;
      LOCAL_DATA_BUS_OE_O <= SAMPLE_READ_I && COUNT_BUS_DIRECTION_I;
    end
  end

endmodule : gss_core
`default_nettype wire

//--- gss_core_assertions.sv
`timescale 1ns/1ns
`default_nettype none
module gss_core_chk (
  // clock and reset
  input wire logic MCLK_I,
  input wire logic ARST_N_I,
  input wire logic SRST_I,
  // watched inputs
  input wire logic ACQUISITION_IDLE_I,
  input wire logic [2:0] CPU_ADDR_LOW_BITS_I,
  input wire logic CHANNEL_TOGGLE_TTL_I,
  input wire logic SINGLE_CHANNEL_FLAG_I,
  input wire logic STATUS_READ_N_I,
  input wire logic SAMPLE_READ_I,
  // watched outputs
  input wire logic [1:0] GATE_O,
  input wire logic GATE_PULSE_ONE_O,
  input wire logic STROBE_ENABLE_O,
  input wire logic [1:0] OVERFLOW_FLAGS_O,
  input wire logic BLOCK_DONE_IRQ_N_O,
  input wire logic [2:0] COUNTER_LATCH_SELECT_O,
  input wire logic LOCAL_DATA_BUS_OE_O,
  input wire logic INTERP_INPUT_BUF_EN_O,
  input wire logic BIDIR_BUF_EN_O
);
  default clocking @(posedge MCLK_I); endclocking
  default disable iff (!ARST_N_I);
  property p_sel_idle;
    (ACQUISITION_IDLE_I && $stable(CPU_ADDR_LOW_BITS_I))[*5] |->
      COUNTER_LATCH_SELECT_O == CPU_ADDR_LOW_BITS_I;
  endproperty
  a_sel_idle: assert property (p_sel_idle) else $error("idle select wrong");
  property p_sel_meas;
    (!ACQUISITION_IDLE_I && $stable(CHANNEL_TOGGLE_TTL_I) && $stable(SINGLE_CHANNEL_FLAG_I))[*5]
      |-> COUNTER_LATCH_SELECT_O == {2'b11, CHANNEL_TOGGLE_TTL_I ^ SINGLE_CHANNEL_FLAG_I};
  endproperty
  a_sel_meas: assert property (p_sel_meas) else $error("meas select wrong");
  property p_stat_oe;
    (!STATUS_READ_N_I)[*5] |-> LOCAL_DATA_BUS_OE_O;
  endproperty
  a_stat_oe: assert property (p_stat_oe) else $error("status not driven");
  property p_gate_min;
    $rose(GATE_O[0]) |-> GATE_O[0][*4];
  endproperty
  a_gate_min: assert property (p_gate_min) else $error("gate too short");
  property p_pulse_en;
    GATE_PULSE_ONE_O |-> STROBE_ENABLE_O || $past(STROBE_ENABLE_O);
  endproperty
  a_pulse_en: assert property (p_pulse_en) else $error("pulse while disabled");
  property p_ovf_irq;
    $rose(|OVERFLOW_FLAGS_O) |-> ##[0:2] !BLOCK_DONE_IRQ_N_O;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow without irq");
  property p_srst_clr;
    SRST_I |=> OVERFLOW_FLAGS_O == 2'h0 && GATE_O == 2'h0;
  endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("clear failed");
  property p_rd_buf;
    SAMPLE_READ_I |-> !INTERP_INPUT_BUF_EN_O && BIDIR_BUF_EN_O;
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("read buffers wrong");
endmodule : gss_core_chk
bind gss_core gss_core_chk u_chk (.MCLK_I, .ARST_N_I, .SRST_I, .ACQUISITION_IDLE_I,
  .CPU_ADDR_LOW_BITS_I, .CHANNEL_TOGGLE_TTL_I, .SINGLE_CHANNEL_FLAG_I, .STATUS_READ_N_I,
  .SAMPLE_READ_I, .GATE_O, .GATE_PULSE_ONE_O, .STROBE_ENABLE_O, .OVERFLOW_FLAGS_O,
  .BLOCK_DONE_IRQ_N_O, .COUNTER_LATCH_SELECT_O, .LOCAL_DATA_BUS_OE_O,
  .INTERP_INPUT_BUF_EN_O, .BIDIR_BUF_EN_O);
`default_nettype wire

//--- gss_pkg.sv
package gss_pkg;
  // clock period and documented times
  localparam int CLK_PERIOD_NS = 50;
  localparam int GATE_MIN_NS = 200;
  localparam int GATE_MIN_CYC = (GATE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CARRY_DLY_NS = 50;
  localparam int CARRY_DLY_CYC = (CARRY_DLY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_DELAY_STAGES = 3;
  localparam int STROBE_DELAY_NS = 800;
  // divider range
  localparam int DIV_MIN = 1;
  localparam int DIV_MAX = 16;
  localparam logic [3:0] DIV_RESET = 4'h0;
  // latch select patterns during measurement
  localparam logic [1:0] SEL_UPPER_MEAS = 2'h3;
  // status bit positions on local_data_bus
  localparam int ST_EXT_ARM = 0;
  localparam int ST_RAM_TC = 1;
  localparam int ST_OVF_A = 2;
  localparam int ST_OVF_B = 3;
  // sample word field positions
  localparam int SW_INTERP_LSB = 0;
  localparam int SW_TOT_LSB = 4;
  localparam int SW_WIDTH = 6;
  typedef enum logic [1:0] {GS_IDLE, GS_SYNC, GS_PULSE} gss_gate_t;
endpackage : gss_pkg

//--- gss_seq_model.sv
`timescale 1ns/1ns
`default_nettype none
module gss_seq_model (
  // clock and command
  input wire logic clk_i,
  input wire logic go_i,
  input wire logic [1:0] carry_i,
  // count board side
  output logic trig_o,
  output logic wr_o,
  output logic [1:0] carry_o
);
  int n = 0;
  initial {trig_o, wr_o, carry_o} = 4'h0;
  always @(posedge clk_i) begin
    n <= go_i ? 1 : (n != 0 && n < 60) ? n + 1 : 0;
    trig_o <= go_i || n != 0;
    wr_o <= (n > 30 && n < 34) || (n > 40 && n < 44);
    carry_o <= (n > 30) ? carry_i : ~carry_i;
  end
endmodule : gss_seq_model
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb;
  import gss_pkg::*;
  logic MCLK_I = 0, ARST_N_I = 0, SRST_I = 0, BLOCK_DONE_I = 0, EXT_ARM_STATE_I = 0;
  logic RAM_TC_I = 0, ACQUISITION_IDLE_I = 1, CHANNEL_TOGGLE_TTL_I = 0, go = 0;
  logic SINGLE_CHANNEL_FLAG_I = 0, CHANNEL_TOGGLE_IN_I = 0, INTERP_VALID_I = 0;
  logic INTERP_RAM_SELECT_I = 0, SAMPLE_READ_I = 0, COUNT_BUS_DIRECTION_I = 0;
  logic STATUS_READ_N_I = 1, seen_p = 0, seen_we = 0, seen_swe = 0, seen_p2 = 0, seen_tf = 0;
  logic [3:0] DIV_RATIO_I = 4'h1, INTERP_DATA_I = 4'h0;
  logic [2:0] CPU_ADDR_LOW_BITS_I = 3'h0, COUNTER_LATCH_SELECT_O;
  logic [1:0] TERMINAL_COUNT_I = 2'h0, COUNTER_MSB_CARRY_I = 2'h0, carry = 2'h0;
  logic [15:0] TERMINAL_RELOAD_I = 16'h0004, LOCAL_DATA_BUS_I = 16'h0000;
  logic TIMING_TRIGGER_I, SAMPLE_WRITE_STROBE_I, SCALED_COUNT_CLOCK_O, STROBE_ENABLE_O;
  logic GATE_PULSE_ONE_O, GATE_PULSE_TWO_O, BLOCK_DONE_IRQ_N_O, INTERP_INPUT_BUF_EN_O;
  logic START_RAM_WE_O, STOP_RAM_WE_O, BIDIR_BUF_EN_O, LOCAL_DATA_BUS_OE_O;
  logic [1:0] LATCH_CARRY_FLAGS_I, GATE_O, TIMER_TERMINAL_FLAG_O, OVERFLOW_FLAGS_O;
  logic [5:0] SAMPLE_WORD_O;
  logic [15:0] LOCAL_DATA_BUS_O;
  int fail_count = 0, n_compared = 0, cyc = 0, g_at = -1, se_at = -1, go_at = 0, w = 0, i, k = 0;

  gss_core DUT (.MCLK_I, .ARST_N_I, .SRST_I, .DIV_RATIO_I, .TIMING_TRIGGER_I,
    .TERMINAL_COUNT_I, .TERMINAL_RELOAD_I, .BLOCK_DONE_I, .EXT_ARM_STATE_I, .RAM_TC_I,
    .ACQUISITION_IDLE_I, .CPU_ADDR_LOW_BITS_I, .CHANNEL_TOGGLE_TTL_I,
    .SINGLE_CHANNEL_FLAG_I, .CHANNEL_TOGGLE_IN_I, .INTERP_VALID_I, .INTERP_DATA_I,
    .LATCH_CARRY_FLAGS_I, .SAMPLE_WRITE_STROBE_I, .INTERP_RAM_SELECT_I, .SAMPLE_READ_I,
    .COUNT_BUS_DIRECTION_I, .COUNTER_MSB_CARRY_I, .STATUS_READ_N_I, .LOCAL_DATA_BUS_I,
    .SCALED_COUNT_CLOCK_O, .GATE_O, .TIMER_TERMINAL_FLAG_O, .STROBE_ENABLE_O,
    .GATE_PULSE_ONE_O, .GATE_PULSE_TWO_O, .BLOCK_DONE_IRQ_N_O, .COUNTER_LATCH_SELECT_O,
    .INTERP_INPUT_BUF_EN_O, .SAMPLE_WORD_O, .START_RAM_WE_O, .STOP_RAM_WE_O,
    .BIDIR_BUF_EN_O, .LOCAL_DATA_BUS_O, .LOCAL_DATA_BUS_OE_O, .OVERFLOW_FLAGS_O);
  gss_seq_model u_seq (.clk_i(MCLK_I), .go_i(go), .carry_i(carry),
    .trig_o(TIMING_TRIGGER_I), .wr_o(SAMPLE_WRITE_STROBE_I), .carry_o(LATCH_CARRY_FLAGS_I));

  initial begin
    forever #25 MCLK_I = ~MCLK_I;
  end
  // output watchers
  always @(negedge MCLK_I) begin
    cyc++;
    if (GATE_O[0] === 1'b1) w++;
    if (GATE_O[0] === 1'b1 && g_at < 0) g_at = cyc;
    if (STROBE_ENABLE_O === 1'b1 && se_at < 0) se_at = cyc;
    if (GATE_PULSE_ONE_O === 1'b1) seen_p = 1;
    if (GATE_PULSE_TWO_O === 1'b1) seen_p2 = 1;
    if (TIMER_TERMINAL_FLAG_O === 2'h0) seen_tf = 1;
    if (START_RAM_WE_O === 1'b1) seen_we = 1;
    if (STOP_RAM_WE_O === 1'b1) seen_swe = 1;
  end

  task chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask : chk
  task fin(input string s);
    $display("test %s done", s);
  endtask : fin
  task print_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (6) @(posedge MCLK_I);
    ARST_N_I <= 1'b1;
    @(negedge MCLK_I) chk(BLOCK_DONE_IRQ_N_O, 16'h1, "irq after reset");
    for (i = 0; i < 8; i++) begin
      @(posedge MCLK_I) CPU_ADDR_LOW_BITS_I <= i[2:0];
      repeat (5) @(posedge MCLK_I);
      @(negedge MCLK_I) chk(COUNTER_LATCH_SELECT_O, i[2:0], "idle select");
    end
    fin("idle select");
    @(posedge MCLK_I) ACQUISITION_IDLE_I <= 1'b0;
    for (i = 0; i < 4; i++) begin
      @(posedge MCLK_I) {SINGLE_CHANNEL_FLAG_I, CHANNEL_TOGGLE_TTL_I} <= i[1:0];
      repeat (5) @(posedge MCLK_I);
      @(negedge MCLK_I) chk(COUNTER_LATCH_SELECT_O, {2'b11, i[1] ^ i[0]}, "sel");
    end
    fin("measure select");
    @(posedge MCLK_I) EXT_ARM_STATE_I <= 1'b1;
    STATUS_READ_N_I <= 1'b0;
    repeat (5) @(posedge MCLK_I);
    @(negedge MCLK_I) chk({LOCAL_DATA_BUS_OE_O, LOCAL_DATA_BUS_O[3:0]}, 16'h11, "st");
    @(posedge MCLK_I) STATUS_READ_N_I <= 1'b1;
    INTERP_DATA_I <= 4'ha;
    INTERP_VALID_I <= 1'b1;
    carry <= 2'h1;
    go <= 1'b1;
    go_at = cyc;
    @(posedge MCLK_I) go <= 1'b0;
    repeat (90) @(posedge MCLK_I);
    @(negedge MCLK_I) chk(g_at > 0 && se_at - g_at >= TRIG_DELAY_STAGES, 1, "delay");
    chk(se_at - go_at <= STROBE_DELAY_NS / CLK_PERIOD_NS, 1, "arm to strobe");
    chk(w >= GATE_MIN_CYC, 1, "gate width");
    chk({seen_p, seen_p2, seen_tf}, 16'h7, "first pulse");
    chk({seen_we, seen_swe, SAMPLE_WORD_O}, {2'b10, 6'h1a}, "sample word");
    chk({INTERP_INPUT_BUF_EN_O, BIDIR_BUF_EN_O}, 16'h2, "input buffers");
    @(posedge MCLK_I) SAMPLE_READ_I <= 1'b1;
    COUNT_BUS_DIRECTION_I <= 1'b1;
    CHANNEL_TOGGLE_IN_I <= 1'b1;
    LOCAL_DATA_BUS_I <= 16'h1234;
    @(negedge MCLK_I) chk({INTERP_INPUT_BUF_EN_O, BIDIR_BUF_EN_O}, 16'h1, "read bufs");
    @(posedge MCLK_I) SAMPLE_READ_I <= 1'b0;
    COUNTER_MSB_CARRY_I <= 2'h1;
    @(negedge MCLK_I) chk(LOCAL_DATA_BUS_O, 16'h1234, "read bus");
    chk(LOCAL_DATA_BUS_OE_O, 16'h1, "read bus drive");
    fin("trigger and sample");
    repeat (6) @(posedge MCLK_I);
    @(negedge MCLK_I) chk({BLOCK_DONE_IRQ_N_O, OVERFLOW_FLAGS_O}, 16'h1, "overflow");
    @(posedge MCLK_I) STATUS_READ_N_I <= 1'b0;
    COUNTER_MSB_CARRY_I <= 2'h0;
    repeat (5) @(posedge MCLK_I);
    @(negedge MCLK_I) chk(LOCAL_DATA_BUS_O[3:0], 16'h5, "overflow status");
    @(posedge MCLK_I) SRST_I <= 1'b1;
    STATUS_READ_N_I <= 1'b1;
    @(posedge MCLK_I) SRST_I <= 1'b0;
    @(negedge MCLK_I) chk({BLOCK_DONE_IRQ_N_O, OVERFLOW_FLAGS_O}, 16'h4, "clear");
    @(posedge MCLK_I) BLOCK_DONE_I <= 1'b1;
    repeat (5) @(posedge MCLK_I);
    @(negedge MCLK_I) chk(BLOCK_DONE_IRQ_N_O, 16'h0, "block done");
    fin("overflow and irq");
    @(posedge MCLK_I) DIV_RATIO_I <= 4'h4;
    repeat (4) @(posedge MCLK_I);
    for (i = 0; i < 16; i++) begin
      @(negedge MCLK_I) if (SCALED_COUNT_CLOCK_O === 1'b1) k++;
    end
    chk(k[15:0], 16'h4, "divider");
    fin("divider");
    print_verdict;
  end
  // hang guard
  initial begin
    repeat (3000) @(posedge MCLK_I);
    fail_count++;
    print_verdict;
  end
endmodule : tb
`default_nettype wire
